/* hdl/flash_read_config_status.sv */
`timescale 1ns/100ps
// Contract
// - Clear-status command clears sticky bits 5,4,3,1, supply bit included; bits 7,6,2 stay live.
// - Engine sets and clears bits 7,6,2; sets only sticky error bits 5,4,3,1.
// - Device reset clears the sticky error bits 5,4,3,1; bits 7,6,2 stay live.
// - In identifier mode, word offset 5 reads back the configuration word.
// - Bit 15: 1 asynchronous page reads (default), 0 synchronous burst reads.
// - Burst waits delay-code clocks after address strobe before first word; code 0 waits one clock.
// - Bit 10 sets stall indicator polarity: 0 low, 1 high active.
// - Bit 9 sets data hold: 0 one clock, 1 two clocks.
// - Bit 8: 0 stall released with data, 1 one data cycle earlier.
// - Bit 6 selects burst clock edge: 0 falling, 1 rising.
// - Bit 3: 0 wraps within burst length, 1 runs on.
// - Bits 2:0 burst size: 001 four, 010 eight, 011 sixteen, 111 continuous.
// - Byte-address packages take the word from address bits 16:1.
// - Setup then confirm with value on address; else flag bits 5 and 4.
module flash_read_config_status (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Flash bus pins
    input  wire logic        chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic        address_valid_strobe_n,
    input  wire logic        burst_clk,
    input  wire logic [16:0] addr,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    output logic             stall_out,
    // Package strap
    input  wire logic        byte_address_package,
    // Array side
    output logic      [16:0] array_addr,
    input  wire logic [15:0] array_data,
    // Internal program engine
    input  wire logic        engine_busy,
    input  wire logic        erase_suspended,
    input  wire logic        program_suspended,
    input  wire logic [7:0]  engine_error_set,
    // Observation
    output logic      [15:0] read_configuration_word,
    output logic      [7:0]  flash_state_word
);

    typedef struct packed {
        logic [1:0]                   ce_s;
        logic [1:0]                   oe_s;
        logic [1:0]                   we_s;
        logic [1:0]                   strobe_s;
        logic [1:0]                   bclk_s;
        logic [16:0]                  addr_m;
        logic [16:0]                  addr_s;
        logic [7:0]                   cmd_m;
        logic [7:0]                   cmd_s;
        logic                         we_p;
        logic                         strobe_p;
        logic                         bclk_p;
        logic [1:0]                   strap_s;
        logic                         byte_pkg;
        logic [15:0]                  cfg;
        logic [7:0]                   sticky;
        logic                         setup_pending;
        flash_cfg_pkg::read_mode_e    mode;
        flash_cfg_pkg::burst_state_e  bst;
        logic [2:0]                   delay_cnt;
        logic                         hold_cnt;
        logic [16:0]                  baddr;
        logic [15:0]                  dq;
        logic                         dq_oe;
        logic                         stall_act;
    } state_s;

    state_s q;
    state_s d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] word_offset(input logic [16:0] a, input logic byte_pkg);
        word_offset = byte_pkg ? a[16:1] : a[15:0];
    endfunction

    function automatic logic [16:0] next_addr(input logic [16:0] a, input logic [15:0] c);
        logic [16:0] m;
        m = 17'h0_0000;
        case (c[flash_cfg_pkg::CFG_SIZE_HI:0])
            flash_cfg_pkg::SIZE_4:  m = flash_cfg_pkg::MASK_4;
            flash_cfg_pkg::SIZE_8:  m = flash_cfg_pkg::MASK_8;
            flash_cfg_pkg::SIZE_16: m = flash_cfg_pkg::MASK_16;
            default:                m = 17'h0_0000;
        endcase
        // Only linear order is implemented
        if (c[flash_cfg_pkg::CFG_NOWRAP_BIT] || m == 17'h0_0000) begin
            next_addr = a + 17'h0_0001;
        end else begin
            next_addr = (a & ~m) | ((a + 17'h0_0001) & m);
        end
    endfunction

    logic        we_rise;
    logic        strobe_rise;
    logic        bedge;
    logic [2:0]  delay_code;
    logic        hold_two;
    logic [7:0]  live_status;
    logic [15:0] cfg_value;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.ce_s   = {q.ce_s[0], chip_enable_n};
        d.oe_s   = {q.oe_s[0], output_enable_n};
        d.we_s   = {q.we_s[0], write_enable_n};
        d.strobe_s = {q.strobe_s[0], address_valid_strobe_n};
        d.bclk_s = {q.bclk_s[0], burst_clk};
        d.addr_m = addr;
        d.addr_s = q.addr_m;
        d.cmd_m  = dq_in[7:0];
        d.cmd_s  = q.cmd_m;
        d.we_p   = q.we_s[1];
        d.strobe_p = q.strobe_s[1];
        d.bclk_p = q.bclk_s[1];

        we_rise  = q.we_s[1] && !q.we_p && !q.ce_s[1];
        strobe_rise = q.strobe_s[1] && !q.strobe_p;
        bedge    = q.cfg[flash_cfg_pkg::CFG_EDGE_BIT] ?
                   (q.bclk_s[1] && !q.bclk_p) : (!q.bclk_s[1] && q.bclk_p);
        delay_code = q.cfg[flash_cfg_pkg::CFG_DELAY_HI:flash_cfg_pkg::CFG_DELAY_LO];
        hold_two   = q.cfg[flash_cfg_pkg::CFG_HOLD_BIT];
        cfg_value  = word_offset(q.addr_s, q.byte_pkg);

        // Package strap is a pin: three flip-flops before any use
        d.strap_s  = {q.strap_s[0], byte_address_package};
        d.byte_pkg = q.strap_s[1];

        // Command interface
        if (we_rise) begin
            if (q.setup_pending) begin
                d.setup_pending = 1'b0;
                d.mode          = flash_cfg_pkg::RD_ARRAY;
                if (q.cmd_s == flash_cfg_pkg::CMD_CFG_CONFIRM) begin
                    d.cfg = cfg_value;
                end else begin
                    d.sticky = q.sticky | flash_cfg_pkg::SEQ_ERR_BITS;
                    d.mode   = flash_cfg_pkg::RD_STATUS;
                end
            end else begin
                case (q.cmd_s)
                    flash_cfg_pkg::CMD_CLEAR_STATUS: d.sticky = 8'h00;
                    flash_cfg_pkg::CMD_CFG_SETUP:    d.setup_pending = 1'b1;
                    flash_cfg_pkg::CMD_READ_STATUS:  d.mode = flash_cfg_pkg::RD_STATUS;
                    flash_cfg_pkg::CMD_READ_IDENT:   d.mode = flash_cfg_pkg::RD_IDENT;
                    flash_cfg_pkg::CMD_READ_ARRAY:   d.mode = flash_cfg_pkg::RD_ARRAY;
                    default:                         d.mode = q.mode;
                endcase
            end
        end

        // Engine error events win over a clear in the same cycle
        d.sticky = d.sticky | (engine_error_set & flash_cfg_pkg::STICKY_MASK);

        // Burst sequencer, only in synchronous mode
        d.stall_act = 1'b0;
        case (q.bst)
            flash_cfg_pkg::B_IDLE: begin
                if (strobe_rise && !q.ce_s[1] &&
                    !q.cfg[flash_cfg_pkg::CFG_TIMING_BIT]) begin
                    d.bst       = flash_cfg_pkg::B_DELAY;
                    d.delay_cnt = 3'h0;
                    d.baddr     = q.addr_s;
                    d.stall_act = 1'b1;
                end
            end
            flash_cfg_pkg::B_DELAY: begin
                d.stall_act = 1'b1;
                if (bedge) begin
                    d.delay_cnt = q.delay_cnt + 3'h1;
                    if (q.delay_cnt + 3'h1 >= delay_code ||
                        delay_code < flash_cfg_pkg::DELAY_MIN) begin
                        d.bst       = flash_cfg_pkg::B_DATA;
                        d.hold_cnt  = 1'b0;
                        d.dq        = array_data;
                        // Array address runs one word ahead of the word shown
                        d.baddr     = next_addr(q.baddr, q.cfg);
                        d.stall_act = 1'b0;
                    end else if (q.cfg[flash_cfg_pkg::CFG_EARLY_BIT] &&
                                 q.delay_cnt + 3'h2 >= delay_code) begin
                        d.stall_act = 1'b0;
                    end
                end else if (q.cfg[flash_cfg_pkg::CFG_EARLY_BIT] &&
                             q.delay_cnt + 3'h1 >= delay_code) begin
                    d.stall_act = 1'b0;
                end
            end
            flash_cfg_pkg::B_DATA: begin
                if (bedge) begin
                    if (hold_two && !q.hold_cnt) begin
                        d.hold_cnt = 1'b1;
                    end else begin
                        d.hold_cnt = 1'b0;
                        d.baddr    = next_addr(q.baddr, q.cfg);
                        d.dq       = array_data;
                    end
                end
            end
            default: d.bst = flash_cfg_pkg::B_IDLE;
        endcase
        if (q.ce_s[1]) begin
            d.bst = flash_cfg_pkg::B_IDLE;
        end

        // Asynchronous reads
        live_status = {!engine_busy, erase_suspended, 3'b000, program_suspended, 2'b00}
                      | q.sticky;
        // A burst word stands until the sequencer replaces it
        if (d.bst != flash_cfg_pkg::B_DATA) begin
            case (q.mode)
                flash_cfg_pkg::RD_STATUS: d.dq = {8'h00, live_status};
                flash_cfg_pkg::RD_IDENT:  d.dq = (word_offset(q.addr_s, q.byte_pkg) ==
                                                  flash_cfg_pkg::CFG_OFFSET) ?
                                                 q.cfg : flash_cfg_pkg::IDENT_FILL;
                default:                  d.dq = array_data;
            endcase
        end
        d.dq_oe = !q.ce_s[1] && !q.oe_s[1];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.ce_s   <= 2'b11;
            q.oe_s   <= 2'b11;
            q.we_s   <= 2'b11;
            q.strobe_s <= 2'b11;
            q.we_p   <= 1'b1;
            q.strobe_p <= 1'b1;
            q.cfg    <= flash_cfg_pkg::CFG_RESET;
            q.mode   <= flash_cfg_pkg::RD_ARRAY;
            q.bst    <= flash_cfg_pkg::B_IDLE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign dq_out                  = q.dq;
    assign dq_oe                   = q.dq_oe;
    assign stall_out               = q.cfg[flash_cfg_pkg::CFG_STALL_POL] ?
                                     q.stall_act : !q.stall_act;
    assign array_addr              = (q.bst == flash_cfg_pkg::B_IDLE) ? q.addr_s : q.baddr;
    assign read_configuration_word = q.cfg;
    assign flash_state_word        = {!engine_busy, erase_suspended, 3'b000,
                                      program_suspended, 2'b00} | q.sticky;

endmodule

/* pkg/flash_cfg_pkg.sv */
package flash_cfg_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_CFG_SETUP    = 8'h60;
    localparam logic [7:0] CMD_CFG_CONFIRM  = 8'h03;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;

    // ------------------------------------------------------------------
    // Read configuration word
    // ------------------------------------------------------------------
    localparam logic [15:0] CFG_RESET       = 16'hBFCF;
    localparam logic [15:0] CFG_OFFSET      = 16'h0005;
    localparam int          CFG_TIMING_BIT  = 15;
    localparam int          CFG_DELAY_HI    = 13;
    localparam int          CFG_DELAY_LO    = 11;
    localparam int          CFG_STALL_POL   = 10;
    localparam int          CFG_HOLD_BIT    = 9;
    localparam int          CFG_EARLY_BIT   = 8;
    localparam int          CFG_ORDER_BIT   = 7;
    localparam int          CFG_EDGE_BIT    = 6;
    localparam int          CFG_NOWRAP_BIT  = 3;
    localparam int          CFG_SIZE_HI     = 2;
    localparam logic [2:0]  SIZE_4          = 3'h1;
    localparam logic [2:0]  SIZE_8          = 3'h2;
    localparam logic [2:0]  SIZE_16         = 3'h3;
    localparam logic [16:0] MASK_4          = 17'h0_0003;
    localparam logic [16:0] MASK_8          = 17'h0_0007;
    localparam logic [16:0] MASK_16         = 17'h0_000F;
    localparam logic [2:0]  DELAY_MIN       = 3'h2;

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    localparam int          ST_READY_BIT    = 7;
    localparam int          ST_ESUSP_BIT    = 6;
    localparam int          ST_ERASE_BIT    = 5;
    localparam int          ST_PROG_BIT     = 4;
    localparam int          ST_SUPPLY_BIT   = 3;
    localparam int          ST_PSUSP_BIT    = 2;
    localparam int          ST_LOCK_BIT     = 1;
    localparam logic [7:0]  STICKY_MASK     = 8'h3A;
    localparam logic [7:0]  SEQ_ERR_BITS    = 8'h30;

    // Identifier answer for offsets other than the configuration word
    localparam logic [15:0] IDENT_FILL      = 16'h0000;

    typedef enum logic [1:0] {
        RD_ARRAY,
        RD_STATUS,
        RD_IDENT
    } read_mode_e;

    typedef enum logic [1:0] {
        B_IDLE,
        B_DELAY,
        B_DATA
    } burst_state_e;

endpackage

/* sim/flash_cfg_props.sv */
`timescale 1ns/100ps
module flash_cfg_props (
    // Watched design ports
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        chip_enable_n,
    input wire logic        write_enable_n,
    input wire logic        engine_busy,
    input wire logic        erase_suspended,
    input wire logic        program_suspended,
    input wire logic [7:0]  engine_error_set,
    input wire logic        dq_oe,
    input wire logic        stall_out,
    input wire logic [15:0] read_configuration_word,
    input wire logic [7:0]  flash_state_word
);
    // ------------------------------------------------------------------
    // Cycles since the write strobe last moved
    // ------------------------------------------------------------------
    logic [3:0] quiet_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) quiet_q <= 4'h0;
        else if ($changed(write_enable_n)) quiet_q <= 4'h0;
        else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    cfg_reset_val_a: assert property ($rose(rst_n) |->
        read_configuration_word == flash_cfg_pkg::CFG_RESET) else $error("config reset value");
    state_reset_a: assert property ($rose(rst_n) |->
        (flash_state_word & flash_cfg_pkg::STICKY_MASK) == 8'h00) else $error("sticky after reset");
    engine_bits_a: assert property (flash_state_word[7] == !engine_busy &&
        flash_state_word[6] == erase_suspended && flash_state_word[2] == program_suspended)
        else $error("engine status bits");
    sticky_set_a: assert property (|(engine_error_set & flash_cfg_pkg::STICKY_MASK) |=>
        (flash_state_word & $past(engine_error_set) & 8'h3A) == ($past(engine_error_set) & 8'h3A))
        else $error("sticky bit not set");
    sticky_hold_a: assert property (|($past(flash_state_word) & ~flash_state_word & 8'h3A)
        |-> quiet_q < 4'h8) else $error("sticky bit fell without command");
    cfg_by_cmd_a: assert property ($changed(read_configuration_word) |-> quiet_q < 4'h8)
        else $error("config changed without command");
    oe_off_a: assert property (chip_enable_n [*5] |-> !dq_oe) else $error("drive while idle");
    stall_idle_a: assert property (chip_enable_n [*6] |->
        stall_out == !read_configuration_word[10]) else $error("stall idle level");
    cover property (flash_state_word[5] && flash_state_word[4]);
    cover property ($changed(read_configuration_word));
    cover property ($fell(stall_out) && !chip_enable_n);
endmodule
bind flash_read_config_status flash_cfg_props flash_cfg_props_i (.clk(clk), .rst_n(rst_n),
    .chip_enable_n(chip_enable_n), .write_enable_n(write_enable_n), .engine_busy(engine_busy),
    .erase_suspended(erase_suspended), .program_suspended(program_suspended),
    .engine_error_set(engine_error_set), .dq_oe(dq_oe), .stall_out(stall_out),
    .read_configuration_word(read_configuration_word), .flash_state_word(flash_state_word));

/* sim/flash_host_model.sv */
`timescale 1ns/100ps
module flash_host_model (
    // Clock and strap
    input  wire logic        clk,
    input  wire logic        byte_mode,
    // Flash bus pins
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             strobe_n,
    output logic             bclk,
    output logic      [16:0] addr,
    output logic      [15:0] dq,
    input  wire logic [15:0] dq_out
);
    initial begin
        {ce_n, oe_n, we_n, strobe_n, bclk} = 5'h1E;
        addr = 17'h0_0000;
        dq = 16'h0000;
    end
    function automatic logic [16:0] pins(input logic [15:0] w);
        return byte_mode ? {w, 1'b0} : {1'b0, w};
    endfunction
    task automatic cmd(input logic [15:0] w, input logic [7:0] c);
        @(posedge clk) ce_n <= 1'b0;
        addr <= pins(w);
        dq <= {8'h00, c};
        we_n <= 1'b0;
        repeat (4) @(posedge clk);
        we_n <= 1'b1;
        repeat (4) @(posedge clk);
        ce_n <= 1'b1;
        dq <= ~dq;
        addr <= ~addr;
        repeat (4) @(posedge clk);
    endtask
    // Reserved bits 14 and 5:4 are expected zero in every value handed in
    task automatic set_cfg(input logic [15:0] v);
        cmd(16'h0000, flash_cfg_pkg::CMD_CLEAR_STATUS);
        cmd(16'h0000, flash_cfg_pkg::CMD_CFG_SETUP);
        cmd(v, flash_cfg_pkg::CMD_CFG_CONFIRM);
    endtask
    task automatic rd(input logic [15:0] w, output logic [15:0] d);
        @(posedge clk) ce_n <= 1'b0;
        oe_n <= 1'b0;
        addr <= pins(w);
        repeat (8) @(posedge clk);
        d = dq_out;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic start_burst(input logic [15:0] w);
        @(posedge clk) ce_n <= 1'b0;
        strobe_n <= 1'b0;
        addr <= pins(w);
        repeat (4) @(posedge clk);
        strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // Burst clock only runs inside a burst
    task automatic tick();
        bclk <= 1'b1;
        repeat (4) @(posedge clk);
        bclk <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Chip enable high ends a burst; the burst clock already rests low
    task automatic end_burst();
        @(posedge clk) ce_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* sim/flash_read_config_status_tb.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module flash_read_config_status_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0, busy = 1'b0, esusp = 1'b0, psusp = 1'b0;
    logic [7:0] err = 8'h00;
    logic ce_n, oe_n, we_n, strobe_n, bclk, dq_oe, stall;
    logic [16:0] addr, array_addr;
    logic [15:0] dq_in, dq_out, cfg, rdata;
    logic [7:0] state;
    int miscompares = 0, num_checks = 0, cycles = 0, n;
    initial forever #12.5 clk = ~clk;
    flash_host_model flash_host_model_i (.clk(clk), .byte_mode(strap), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .strobe_n(strobe_n), .bclk(bclk), .addr(addr), .dq(dq_in),
        .dq_out(dq_out));
    flash_read_config_status flash_read_config_status_i (.clk(clk), .rst_n(rst_n),
        .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .address_valid_strobe_n(strobe_n), .burst_clk(bclk), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .stall_out(stall), .byte_address_package(strap),
        .array_addr(array_addr), .array_data(array_addr[15:0] ^ 16'hA5A5),
        .engine_busy(busy), .erase_suspended(esusp), .program_suspended(psusp),
        .engine_error_set(err), .read_configuration_word(cfg), .flash_state_word(state));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk) rst_n <= 1'b0;
        strap <= s;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] w, input logic [15:0] e);
        flash_host_model_i.cmd(16'h0000, c);
        flash_host_model_i.rd(w, rdata);
        `CHK(rdata, e)
    endtask
    // Configure, start a burst and count burst clocks while stall shows its active level
    task automatic burst(input logic [15:0] c, input logic [15:0] w, input logic act);
        flash_host_model_i.set_cfg(c);
        flash_host_model_i.start_burst(w);
        n = 0;
        while (stall === act && n < 10) begin
            flash_host_model_i.tick();
            n++;
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        do_reset(1'b0);
        `CHK(cfg, flash_cfg_pkg::CFG_RESET)
        rd_chk(flash_cfg_pkg::CMD_READ_IDENT, 16'h0005, flash_cfg_pkg::CFG_RESET);
        rd_chk(flash_cfg_pkg::CMD_READ_IDENT, 16'h0004, flash_cfg_pkg::IDENT_FILL);
        rd_chk(flash_cfg_pkg::CMD_READ_STATUS, 16'h0000, 16'h0080);
        $display("test reset values done");
        flash_host_model_i.set_cfg(16'h9883);
        `CHK(cfg, 16'h9883)
        rd_chk(flash_cfg_pkg::CMD_READ_IDENT, 16'h0005, 16'h9883);
        flash_host_model_i.cmd(16'h0000, flash_cfg_pkg::CMD_CFG_SETUP);
        rd_chk(flash_cfg_pkg::CMD_READ_STATUS, 16'h0000, 16'h00B0);
        `CHK(cfg, 16'h9883)
        rd_chk(flash_cfg_pkg::CMD_CLEAR_STATUS, 16'h0000, 16'h0080);
        $display("test config write done");
        @(posedge clk) err <= 8'hFF;
        @(posedge clk) err <= 8'h00;
        {busy, esusp, psusp} <= 3'b111;
        repeat (4) @(posedge clk);
        `CHK(state, 8'h7E)
        {busy, esusp, psusp} <= 3'b000;
        repeat (4) @(posedge clk);
        `CHK(state, 8'hBA)
        do_reset(1'b1);
        `CHK(state, 8'h80)
        flash_host_model_i.set_cfg(16'h9883);
        `CHK(cfg, 16'h9883)
        $display("test status and strap done");
        do_reset(1'b0);
        burst(16'h14CF, 16'h0010, 1'b1);
        `CHK(n, 2)
        `CHK(dq_out, 16'h0010 ^ 16'hA5A5)
        flash_host_model_i.tick();
        `CHK(dq_out, 16'h0011 ^ 16'hA5A5)
        flash_host_model_i.end_burst();
        // Delay 3, low stall, early release, falling edge, two-clock hold, wrap of 4
        burst(16'h1B81, 16'h0013, 1'b0);
        `CHK(n, 3 - 1)
        flash_host_model_i.tick();
        `CHK(dq_out, 16'h0013 ^ 16'hA5A5)
        flash_host_model_i.tick();
        `CHK(dq_out, 16'h0013 ^ 16'hA5A5)
        flash_host_model_i.tick();
        `CHK(dq_out, 16'h0010 ^ 16'hA5A5)
        flash_host_model_i.end_burst();
        $display("test burst done");
        finish_test();
    end
endmodule
